// file: udi_pkg.sv
// Shared constants, types and helpers for the data-in burst engine
package udi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, widths, synchroniser latency
    localparam int CLK_MHZ  = 125;
    localparam int DW       = 16;
    localparam int NMODE    = 3;
    localparam int SYNC_LAT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Timing figures in ns, per transfer mode where they vary
    localparam int T_CYC_NS [NMODE] = '{120, 80, 60};
    localparam int T_DVS_NS [NMODE] = '{70, 48, 34};
    localparam int T_DVH_NS [NMODE] = '{10, 10, 10};
    localparam int T_ZIORDY_NS = 20;
    localparam int T_ZAD_NS    = 5;
    localparam int T_SS_NS     = 50;
    localparam int T_FS_NS     = 230;
    localparam int T_RFS_NS    = 75;
    localparam int T_LI_NS     = 100;
    localparam int T_IORDYZ_NS = 30;

    ////////////////////////////////////////////////////////////////////////////
    // Link checksum
    localparam logic [DW-1:0] CRC_SEED = 16'h4abb;
    localparam logic [DW-1:0] CRC_POLY = 16'h1021;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic          dmack_n;
        logic          stop;
        logic          hdmardy_n;
        logic [DW-1:0] dd;
    } udi_host_s;

    localparam udi_host_s HOST_IDLE = '{dmack_n: 1'b1, stop: 1'b0, hdmardy_n: 1'b1, dd: '0};

    typedef enum logic [3:0] {
        S_IDLE, S_REQ, S_ZIORDY, S_ENV, S_ZAD, S_XFER, S_DTERM, S_WSTOP, S_WACK
    } udi_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic int ns_min_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int ns_max_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic logic [DW-1:0] crc_next(input logic [DW-1:0] c, input logic [DW-1:0] d);
        logic [DW-1:0] r;
        logic          fb;
        r = c;
        for (int i = DW - 1; i >= 0; i--) begin
            fb = r[DW-1] ^ d[i];
            r  = {r[DW-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
        end
        return r;
    endfunction

endpackage

// file: udi_sync.sv
// Two-stage synchroniser bank for the host-driven pins
`timescale 1ns/100ps
`default_nettype none
module udi_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // System
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // First stage feeds the second only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule // udi_sync
`default_nettype wire

// file: udi_burst.sv
// Data-in burst engine, device end of the parallel host port
// Notes on behaviour
// - Device raises DMARQ to start; keeps it until first strobe fall.
// - Device drives strobe t_ZIORDY after DMACK, until DMACK negates.
// - Device drives data no sooner than t_ZAD after host is ready.
// - First strobe fall within t_FS of host ready, t_DVS after data.
// - Both strobe edges latch words; setup t_DVS, spacing t_CYC.
// - Data held t_DVH after each edge; repeat until done or paused.
// - Device pauses only after one word, by withholding strobe edges.
// - Host pause by HDMARDY; device stops edges within t_RFS.
// - Device ends: no edges, DMARQ low after t_SS, bus freed.
// - Host ends via HDMARDY then STOP; device drops DMARQ within t_LI.
// - In termination a low strobe is raised within t_LI, no data.
// - Device captures host CRC as DMACK negates, keeps first miscompare.
// - Device releases strobe within t_IORDYZ after DMACK negates.
// - A CRC miscompare is reported as an error at command end.
// - Receiver takes at least two words on entry or resume.
`timescale 1ns/100ps
`default_nettype none
module udi_burst
    import udi_pkg::*;
#(
    parameter int TW = 8
) (
    // System
    input  wire logic          CLK_SYS_I,
    input  wire logic          RSTN_I,
    // Link from host
    input  wire logic          DMACK_N_I,
    input  wire logic          STOP_I,
    input  wire logic          HDMARDY_N_I,
    input  wire logic [DW-1:0] DD_I,
    // Link to host
    output logic               DMARQ_O,
    output logic               DSTROBE_O,
    output logic               DSTROBE_OE_O,
    output logic      [DW-1:0] DD_O,
    output logic               DD_OE_O,
    // Word source
    input  wire logic [1:0]    MODE_I,
    input  wire logic          XFER_REQ_I,
    input  wire logic          TERM_REQ_I,
    input  wire logic          WORD_VALID_I,
    input  wire logic [DW-1:0] WORD_I,
    output logic               WORD_ACK_O,
    // Command status
    input  wire logic          CMD_START_I,
    input  wire logic          CMD_END_I,
    output logic               CRC_ERR_O,
    output logic               BURST_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts
    // fixed counts
    localparam logic [TW-1:0] ZIORDY_C = TW'(ns_min_cyc(T_ZIORDY_NS));
    localparam logic [TW-1:0] ZAD_C    = TW'(ns_min_cyc(T_ZAD_NS));
    localparam logic [TW-1:0] SS_C     = TW'(ns_min_cyc(T_SS_NS));

    // Reaction paths run through the synchroniser, so they must fit the limits
    if (SYNC_LAT > ns_max_cyc(T_RFS_NS) || SYNC_LAT > ns_max_cyc(T_LI_NS)
        || SYNC_LAT > ns_max_cyc(T_IORDYZ_NS)) begin : g_chk_lat
        $error("Synchroniser latency exceeds a reaction limit");
    end
    for (genvar m = 0; m < NMODE; m++) begin : g_chk_mode
        if (SYNC_LAT + ns_min_cyc(T_ZAD_NS) + ns_min_cyc(T_DVS_NS[m])
            > ns_max_cyc(T_FS_NS)) begin : g_fs
            $error("First strobe cannot meet its deadline");
        end
        if (ns_min_cyc(T_CYC_NS[m]) >= 2 ** TW || ns_min_cyc(T_SS_NS) >= 2 ** TW) begin : g_tw
            $error("Timer width too small");
        end
    end

    function automatic int mode_idx(input logic [1:0] m);
        return (int'(m) >= NMODE) ? NMODE - 1 : int'(m);
    endfunction

    function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    udi_host_s     pins_a;
    udi_host_s     pins_s;
    logic          dmack_d_r;
    logic          dmack_rise;
    udi_state_e    st_r;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] cnt_edge_r;
    logic [TW-1:0] cnt_data_r;
    logic [TW-1:0] cyc_c_r;
    logic [TW-1:0] dvs_c_r;
    logic [TW-1:0] dvh_c_r;
    logic          hold_r;
    logic          first_r;
    logic [DW-1:0] crc_r;
    logic          err_r;
    logic          miss;
    logic          in_burst;

    assign pins_a = {DMACK_N_I, STOP_I, HDMARDY_N_I, DD_I};

    udi_sync #(
        .W       ($bits(udi_host_s)),
        .RST_VAL (HOST_IDLE)
    ) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RSTN_I),
        .d_i     (pins_a),
        .q_o     (pins_s)
    );

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            dmack_d_r <= 1'b1;
        end else begin
            dmack_d_r <= pins_s.dmack_n;
        end
    end

    assign dmack_rise = pins_s.dmack_n & ~dmack_d_r;
    assign in_burst   = (st_r != S_IDLE) && (st_r != S_REQ);

    ////////////////////////////////////////////////////////////////////////////
    // Mode timing, latched per burst
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cyc_c_r <= '1;
            dvs_c_r <= '1;
            dvh_c_r <= '1;
        end else if (st_r == S_IDLE) begin
            cyc_c_r <= TW'(ns_min_cyc(T_CYC_NS[mode_idx(MODE_I)]));
            dvs_c_r <= TW'(ns_min_cyc(T_DVS_NS[mode_idx(MODE_I)]));
            dvh_c_r <= TW'(ns_min_cyc(T_DVH_NS[mode_idx(MODE_I)]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencer
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_r         <= S_IDLE;
            tmr_r        <= '0;
            cnt_edge_r   <= '1;
            cnt_data_r   <= '0;
            hold_r       <= 1'b0;
            first_r      <= 1'b0;
            DMARQ_O      <= 1'b0;
            DSTROBE_O    <= 1'b1;
            DSTROBE_OE_O <= 1'b0;
            DD_O         <= '0;
            DD_OE_O      <= 1'b0;
            WORD_ACK_O   <= 1'b0;
        end else begin
            tmr_r      <= sat_inc(tmr_r);
            cnt_edge_r <= sat_inc(cnt_edge_r);
            cnt_data_r <= sat_inc(cnt_data_r);
            WORD_ACK_O <= 1'b0;
            if (dmack_rise && in_burst) begin
                DSTROBE_OE_O <= 1'b0;
                DD_OE_O      <= 1'b0;
                DMARQ_O      <= 1'b0;
                hold_r       <= 1'b0;
                st_r         <= S_IDLE;
            end else begin
                unique case (st_r)
                    S_IDLE: begin
                        DSTROBE_O  <= 1'b1;
                        cnt_edge_r <= '1;
                        first_r    <= 1'b0;
                        // request only with a word ready
                        if (XFER_REQ_I && WORD_VALID_I && pins_s.dmack_n) begin
                            DMARQ_O <= 1'b1;
                            st_r    <= S_REQ;
                        end
                    end
                    S_REQ: begin
                        tmr_r <= '0;
                        if (!pins_s.dmack_n) begin
                            st_r <= S_ZIORDY;
                        end
                    end
                    S_ZIORDY: begin
                        if (tmr_r >= ZIORDY_C) begin
                            DSTROBE_OE_O <= 1'b1;
                            st_r         <= S_ENV;
                        end
                    end
                    S_ENV: begin
                        tmr_r <= '0;
                        if (!pins_s.stop && !pins_s.hdmardy_n) begin
                            st_r <= S_ZAD;
                        end
                    end
                    S_ZAD: begin
                        if (tmr_r >= ZAD_C) begin
                            DD_OE_O    <= 1'b1;
                            DD_O       <= WORD_I;
                            hold_r     <= 1'b1;
                            cnt_data_r <= '0;
                            st_r       <= S_XFER;
                        end
                    end
                    S_XFER: begin
                        if (pins_s.stop) begin
                            DMARQ_O   <= 1'b0;
                            DD_OE_O   <= 1'b0;
                            hold_r    <= 1'b0;
                            DSTROBE_O <= 1'b1;
                            st_r      <= S_WACK;
                        end else if (TERM_REQ_I && !hold_r && first_r) begin
                            tmr_r <= '0;
                            st_r  <= S_DTERM;
                        end else if (hold_r) begin
                            if (cnt_data_r >= dvs_c_r && cnt_edge_r >= cyc_c_r
                                && !pins_s.hdmardy_n) begin
                                DSTROBE_O  <= ~DSTROBE_O;
                                cnt_edge_r <= '0;
                                hold_r     <= 1'b0;
                                first_r    <= 1'b1;
                                WORD_ACK_O <= 1'b1;
                            end
                        end else if (WORD_VALID_I && !WORD_ACK_O && cnt_edge_r >= dvh_c_r) begin
                            DD_O       <= WORD_I;
                            hold_r     <= 1'b1;
                            cnt_data_r <= '0;
                        end
                    end
                    S_DTERM: begin
                        // DMARQ drops t_SS after last edge, or on STOP if that comes first
                        if (pins_s.stop || cnt_edge_r >= SS_C) begin
                            DMARQ_O <= 1'b0;
                            DD_OE_O <= 1'b0;
                            st_r    <= S_WSTOP;
                        end
                    end
                    S_WSTOP: begin
                        if (pins_s.stop) begin
                            DSTROBE_O <= 1'b1;
                            st_r      <= S_WACK;
                        end
                    end
                    S_WACK: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checksum over delivered words
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            crc_r <= CRC_SEED;
        end else if (st_r == S_IDLE) begin
            crc_r <= CRC_SEED;
        end else if (WORD_ACK_O) begin
            crc_r <= crc_next(crc_r, DD_O);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Miscompare tracking and report
    // host CRC valid as DMACK negates
    assign miss = dmack_rise && in_burst && (pins_s.dd != crc_r);

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            err_r     <= 1'b0;
            CRC_ERR_O <= 1'b0;
            BURST_O   <= 1'b0;
        end else begin
            BURST_O <= !pins_s.dmack_n;
            // first miscompare kept, set beats clear
            if (miss) begin
                err_r <= 1'b1;
            end else if (CMD_START_I) begin
                err_r <= 1'b0;
            end
            if (CMD_END_I) begin
                CRC_ERR_O <= err_r | miss;
            end else if (CMD_START_I) begin
                CRC_ERR_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_host_stop;
        $rose(pins_s.stop) && st_r == S_XFER && !dmack_rise;
    endsequence

    sequence s_strobe_edge;
        $changed(DSTROBE_O) && $past(st_r) == S_XFER && $past(hold_r) && !$past(pins_s.stop);
    endsequence

    a_dmarq_first_word: assert property (
        $fell(DMARQ_O) |-> first_r
    ) else $error("DMARQ dropped before first strobe edge");

    a_strobe_ziordy: assert property (
        $rose(DSTROBE_OE_O) |-> $past(tmr_r) >= ZIORDY_C && !$past(pins_s.dmack_n)
    ) else $error("Strobe driven too early");

    a_bus_turn_on: assert property (
        $rose(DD_OE_O) |-> $past(st_r) == S_ZAD && $past(tmr_r) >= ZAD_C
    ) else $error("Data bus driven before t_ZAD");

    a_edge_spacing: assert property (
        s_strobe_edge |-> $past(cnt_edge_r) >= cyc_c_r && $past(cnt_data_r) >= dvs_c_r
    ) else $error("Strobe edge violates setup or spacing");

    a_data_hold: assert property (
        ($changed(DD_O) && st_r == S_XFER) |-> $past(cnt_edge_r) >= dvh_c_r
    ) else $error("Data changed inside hold window");

    a_host_pause: assert property (
        (st_r == S_XFER && pins_s.hdmardy_n && !pins_s.stop) |=> $stable(DSTROBE_O)
    ) else $error("Strobe edge while host paused");

    a_dev_term: assert property (
        ($fell(DMARQ_O) && $past(st_r) == S_DTERM && !$past(pins_s.stop))
            |-> $past(cnt_edge_r) >= SS_C && !DD_OE_O
    ) else $error("Device termination too early or bus kept");

    a_host_term: assert property (
        s_host_stop |=> !DMARQ_O && !DD_OE_O ##1 !DMARQ_O
    ) else $error("DMARQ not dropped after STOP");

    a_term_strobe: assert property (
        (st_r == S_WACK) |-> DSTROBE_O && !WORD_ACK_O
    ) else $error("Strobe low or data during termination");

    a_strobe_release: assert property (
        (dmack_rise && in_burst) |=> !DSTROBE_OE_O && st_r == S_IDLE
    ) else $error("Strobe not released after DMACK");

    a_crc_sticky: assert property (
        (err_r && !CMD_START_I) |=> err_r
    ) else $error("Miscompare flag lost");

endmodule // udi_burst
`default_nettype wire

// file: udi_host.sv
// Behavioural host controller facing the data-in burst engine
`timescale 1ns/100ps
`default_nettype none
module udi_host
    import udi_pkg::*;
(
    // Host clock
    input  wire logic          hclk_i,
    // Device pins
    input  wire logic          dmarq_i,
    input  wire logic          dstrobe_i,
    input  wire logic          dstrobe_oe_i,
    input  wire logic [DW-1:0] dd_dev_i,
    input  wire logic          dd_dev_oe_i,
    // Host pins, data as seen on the wire
    output var  udi_host_s     bus_o
);
    udi_host_s     hb_r      = HOST_IDLE;
    logic          host_oe_r = 1'b0;
    logic [DW-1:0] junk_r    = 16'h5a5a;
    logic [DW-1:0] crc_r     = 16'h0000;
    logic [DW-1:0] rx_q[$];
    logic          pause_en  = 1'b0;
    logic          term_req  = 1'b0;
    logic          bad_crc   = 1'b0;
    logic          done      = 1'b0;
    int            late_n    = 0;

    function automatic logic [DW-1:0] hcrc(input logic [DW-1:0] c, input logic [DW-1:0] d);
        logic [DW-1:0] r;
        r = c;
        for (int i = DW - 1; i >= 0; i--) begin
            r = (r[DW-1] ^ d[i]) ? ({r[DW-2:0], 1'b0} ^ CRC_POLY) : {r[DW-2:0], 1'b0};
        end
        return r;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge hclk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Released bus shows a moving pattern, never the last word
    always_comb begin
        bus_o    = hb_r;
        bus_o.dd = dd_dev_oe_i ? dd_dev_i : (host_oe_r ? hb_r.dd : junk_r);
    end
    always @(posedge hclk_i) junk_r <= junk_r + 16'h3b1d;

    // Both edges latch; rise after STOP ignored
    always @(dstrobe_i) begin
        if (!hb_r.dmack_n && dstrobe_oe_i && !hb_r.stop) begin
            rx_q.push_back(dd_dev_i);
            crc_r = hcrc(crc_r, dd_dev_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever begin
            tick(1);
            if (dmarq_i && hb_r.dmack_n) begin
                // STOP up, ready off before acknowledge
                hb_r.stop      <= 1'b1;
                hb_r.hdmardy_n <= 1'b1;
                tick(2);
                rx_q.delete();
                crc_r = CRC_SEED;
                hb_r.dmack_n <= 1'b0;
                host_oe_r    <= 1'b0;
                tick(1);
                // Ready, held until two words are in
                hb_r.stop      <= 1'b0;
                hb_r.hdmardy_n <= 1'b0;
                // A strobe pause never ends the burst here
                while (dmarq_i && !term_req) begin
                    tick(1);
                    if (pause_en && rx_q.size() >= 2) begin
                        hb_r.hdmardy_n <= 1'b1;
                        late_n = rx_q.size();
                        tick(4);
                        late_n   = rx_q.size() - late_n;
                        pause_en = 1'b0;
                        hb_r.hdmardy_n <= 1'b0;
                    end
                end
                // Host end: ready off, STOP after t_RP
                if (dmarq_i) begin
                    hb_r.hdmardy_n <= 1'b1;
                    tick(2);
                    hb_r.stop <= 1'b1;
                    while (dmarq_i) tick(1);
                end
                // STOP and ready off, then the CRC word
                hb_r.stop      <= 1'b1;
                hb_r.hdmardy_n <= 1'b1;
                tick(1);
                hb_r.dd   <= crc_r ^ {15'h0000, bad_crc};
                host_oe_r <= 1'b1;
                while (!dstrobe_i) tick(1);
                tick(2);
                hb_r.dmack_n <= 1'b1;
                // STOP, ready and CRC held past acknowledge
                tick(2);
                host_oe_r <= 1'b0;
                hb_r.stop <= 1'b0;
                done = 1'b1;
            end
        end
    end
endmodule // udi_host
`default_nettype wire

// file: udi_burst_tb.sv
// Self-checking bench for the data-in burst engine
`timescale 1ns/100ps
`default_nettype none
module udi_burst_tb;
    import udi_pkg::*;
    logic          clk = 1'b0;
    logic          hclk = 1'b0;
    logic          rstn = 1'b0;
    logic [1:0]    mode = 2'h0;
    logic          xfer_req = 1'b0;
    logic          term_req = 1'b0;
    logic          word_valid = 1'b0;
    logic [DW-1:0] word = 16'h0000;
    logic          cmd_start = 1'b0;
    logic          cmd_end = 1'b0;
    logic          dmarq, dstrobe, dstrobe_oe, dd_oe, word_ack, crc_err, burst;
    logic [DW-1:0] dd_o;
    udi_host_s     hbus;
    logic [DW-1:0] lfsr_r = 16'h0056;
    logic [DW-1:0] exp_q[$];
    logic          stall_en = 1'b0;
    logic          exp_err = 1'b0;
    int            stall_n = 0;
    int            cyc = 0;
    int            miscompares = 0;
    int            checks_done = 0;

    always #4 clk = ~clk;
    // Host clock at one eighth of the system clock rate, at a fixed 3.7 ns offset
    initial begin
        #3.7;
        forever #32 hclk = ~hclk;
    end

    udi_burst #(.TW(8)) dut (
        .CLK_SYS_I(clk), .RSTN_I(rstn), .DMACK_N_I(hbus.dmack_n), .STOP_I(hbus.stop),
        .HDMARDY_N_I(hbus.hdmardy_n), .DD_I(hbus.dd), .DMARQ_O(dmarq), .DSTROBE_O(dstrobe),
        .DSTROBE_OE_O(dstrobe_oe), .DD_O(dd_o), .DD_OE_O(dd_oe), .MODE_I(mode),
        .XFER_REQ_I(xfer_req), .TERM_REQ_I(term_req), .WORD_VALID_I(word_valid),
        .WORD_I(word), .WORD_ACK_O(word_ack), .CMD_START_I(cmd_start), .CMD_END_I(cmd_end),
        .CRC_ERR_O(crc_err), .BURST_O(burst));
    udi_host host (.hclk_i(hclk), .dmarq_i(dmarq), .dstrobe_i(dstrobe),
        .dstrobe_oe_i(dstrobe_oe), .dd_dev_i(dd_o), .dd_dev_oe_i(dd_oe), .bus_o(hbus));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [DW-1:0] lfsr(input logic [DW-1:0] s);
        return {s[DW-2:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Ceiling well above four short bursts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    // Source keeps each word until acked; one optional stall
    always @(negedge clk) begin
        if (stall_n > 0) begin
            stall_n--;
            if (stall_n == 0) word_valid <= 1'b1;
        end
        if (word_ack === 1'b1) begin
            exp_q.push_back(word);
            lfsr_r = lfsr(lfsr_r);
            word <= lfsr_r;
            if (stall_en && exp_q.size() == 3) begin
                word_valid <= 1'b0;
                stall_n = 40;
            end
        end
    end

    always @(negedge clk) if (host.host_oe_r) check("dd contention", dd_oe, 0);

    ////////////////////////////////////////////////////////////////////////////
    task automatic run_burst(input logic [1:0] m, input int n, input logic hterm,
                             input logic hpause, input logic bad, input logic stall);
        exp_q.delete();
        mode          = m;
        host.done     = 1'b0;
        host.bad_crc  = bad;
        host.pause_en = hpause;
        stall_en      = stall;
        exp_err       = exp_err | bad;
        xfer_req      = 1'b1;
        while (dmarq !== 1'b1) @(negedge clk);
        xfer_req = 1'b0;
        while (exp_q.size() < n) @(negedge clk);
        if (hterm) host.term_req = 1'b1;
        else term_req = 1'b1;
        while (host.done !== 1'b1) @(negedge clk);
        term_req      = 1'b0;
        host.term_req = 1'b0;
        check("word count", host.rx_q.size(), exp_q.size());
        foreach (exp_q[i]) check("word", host.rx_q[i], exp_q[i]);
        if (hpause) check("late words", host.late_n <= 2, 1);
        check("idle pins", {dmarq, dstrobe_oe, dd_oe, dstrobe}, 4'h1);
        check("burst flag", burst, 0);
    endtask

    task automatic cmd(input logic fin);
        if (fin) cmd_end = 1'b1;
        else cmd_start = 1'b1;
        @(negedge clk);
        cmd_end   = 1'b0;
        cmd_start = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        check("reset pins", {dmarq, dstrobe, dstrobe_oe, dd_oe, crc_err, burst, word_ack}, 7'h20);
        rstn       = 1'b1;
        word_valid = 1'b1;
        word       = lfsr_r;
        @(negedge clk);
        cmd(1'b0);
        run_burst(2'h0, 6, 1'b0, 1'b0, 1'b1, 1'b1);
        check("error before end", crc_err, 0);
        run_burst(2'h1, 8, 1'b1, 1'b1, 1'b0, 1'b0);
        cmd(1'b1);
        check("first miscompare", crc_err, exp_err);
        cmd(1'b0);
        exp_err = 1'b0;
        check("error cleared", crc_err, 0);
        run_burst(2'h2, 10, 1'b0, 1'b0, 1'b0, 1'b0);
        run_burst(2'h3, 12, 1'b1, 1'b0, 1'b0, 1'b1);
        cmd(1'b1);
        check("clean command", crc_err, exp_err);
        complete_run();
    end
endmodule // udi_burst_tb
`default_nettype wire
